// *** rtl/cacc_pkg.sv ***
`default_nettype none
package cacc_pkg;
  localparam int          NMOD          = 5;
  localparam int          CNT_W         = 16;
  localparam int          WD_MOD        = 4;
  localparam int          CLK_HZ        = 10_000_000;
  // prescaler terminal counts
  localparam logic [3:0]  DIV12_LAST    = 4'hb;
  localparam logic [1:0]  DIV4_LAST     = 2'h3;
  localparam logic [2:0]  OSC_DIV_LAST  = 3'h7;
  // counter clock source codes
  localparam logic [2:0]  SRC_DIV12     = 3'h0;
  localparam logic [2:0]  SRC_DIV4      = 3'h1;
  localparam logic [2:0]  SRC_T0_OVF    = 3'h2;
  localparam logic [2:0]  SRC_EXT_CNT   = 3'h3;
  localparam logic [2:0]  SRC_SYSCLK    = 3'h4;
  localparam logic [2:0]  SRC_OSC_DIV8  = 3'h5;
  // reset values
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [15:0] WD_CMP_RST    = 16'hff00;
  localparam logic        WD_EN_RST     = 1'b1;

  typedef enum logic [2:0] {
    CACC_OFF,
    CACC_CAPTURE,
    CACC_SW_TIMER,
    CACC_HS_OUT,
    CACC_PWM8,
    CACC_PWM16,
    CACC_FREQ_OUT
  } cacc_mode_t;
endpackage : cacc_pkg
`default_nettype wire

// *** rtl/cacc_module.sv ***
`default_nettype none
module cacc_module (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic [15:0]        count,
  input  wire logic               tick,
  input  wire cacc_pkg::cacc_mode_t mode,
  input  wire logic               cap_rise_en,
  input  wire logic               cap_fall_en,
  input  wire logic [15:0]        cmp_val,
  input  wire logic               cmp_wr,
  input  wire logic               pin_in,
  input  wire logic               flag_clr,
  output logic [15:0]             cap_val,
  output logic                    flag,
  output logic                    pin_out
);
  typedef struct packed {
    logic        in_s1;
    logic        in_s2;
    logic        in_s3;
    logic [15:0] cap;
    logic        flag;
    logic        out;
  } cacc_mod_st_t;

  cacc_mod_st_t st_q;
  cacc_mod_st_t st_d;
  logic         rise;
  logic         fall;
  logic         match16;
  logic         match8;
  logic         hit;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d       = st_q;
    st_d.in_s1 = pin_in;
    st_d.in_s2 = st_q.in_s1;
    st_d.in_s3 = st_q.in_s2;
    rise       = st_q.in_s2 & ~st_q.in_s3;
    fall       = ~st_q.in_s2 & st_q.in_s3;
    match16    = tick & (count == st_q.cap);
    match8     = tick & (count[7:0] == st_q.cap[7:0]);
    hit        = 1'b0;
    if (cmp_wr && mode != cacc_pkg::CACC_CAPTURE) begin
      st_d.cap = cmp_val;
    end
    case (mode)
      cacc_pkg::CACC_CAPTURE: begin // R03
        if ((rise && cap_rise_en) || (fall && cap_fall_en)) begin
          st_d.cap = count;
          hit      = 1'b1;
        end
      end
      cacc_pkg::CACC_SW_TIMER: begin // R03
        hit = match16;
      end
      cacc_pkg::CACC_HS_OUT: begin // R03
        hit = match16;
        if (match16) begin
          st_d.out = ~st_q.out;
        end
      end
      cacc_pkg::CACC_PWM8: begin // R03
        hit      = match8;
        st_d.out = count[7:0] >= st_q.cap[15:8];
      end
      cacc_pkg::CACC_PWM16: begin // R03
        hit      = match16;
        st_d.out = count >= st_q.cap;
      end
      cacc_pkg::CACC_FREQ_OUT: begin // R03
        hit = match8;
        if (match8) begin
          st_d.out      = ~st_q.out;
          st_d.cap[7:0] = st_q.cap[7:0] + st_q.cap[15:8];
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    // set wins over clear
    if (hit) begin // R11
      st_d.flag = 1'b1;
    end else if (flag_clr) begin
      st_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cap_val = st_q.cap;
  assign flag    = st_q.flag;
  assign pin_out = st_q.out; // R06
endmodule : cacc_module
`default_nettype wire

// *** rtl/cacc_top.sv ***
`default_nettype none
// Functional notes
// (R01) one shared 16-bit counter is the time base of five modules
// (R02) counter clock from sysclk/12, /4, timer0 overflow, ext count, sysclk, osc/8
// (R03) each module runs capture, sw timer, hs out, pwm8, pwm16 or freq out
// (R04) module 4 can also act as the watchdog
// (R05) after any reset the watchdog is enabled with no software action
// (R06) module pins and the external count input go to port pins
// (R07) debug halt freezes counter and modules; capture mode still captures pin edges and sets its flag while halted
// (R08) counting from divided external oscillator works while sysclk runs
// (R09) watchdog lock keeps it enabled until the next reset
// (R10) watchdog timeout without service asserts reset and records the cause
// (R11) overflow and per-module match flags, each with optional interrupt
module cacc_top (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        por_b,
  input  wire logic [2:0]  clk_sel,
  input  wire logic        cnt_run,
  input  wire logic        dbg_halt,
  input  wire logic        t0_ovf,
  input  wire logic        ext_count_input,
  input  wire logic        ext_osc,
  input  wire logic [14:0] mode_sel,
  input  wire logic [4:0]  cap_rise_en,
  input  wire logic [4:0]  cap_fall_en,
  input  wire logic [79:0] cmp_val,
  input  wire logic [4:0]  cmp_wr,
  input  wire logic [4:0]  mod_pin_in,
  input  wire logic [4:0]  mod_flag_clr,
  input  wire logic [4:0]  mod_irq_en,
  input  wire logic        ovf_flag_clr,
  input  wire logic        ovf_irq_en,
  input  wire logic        wd_disable,
  input  wire logic        wd_lock,
  input  wire logic        wd_kick,
  input  wire logic [7:0]  wd_offset,
  input  wire logic        wd_cause_clr,
  output logic [15:0]      count,
  output logic [79:0]      cap_val,
  output logic             ovf_flag,
  output logic [4:0]       mod_flag,
  output logic [4:0]       mod_pin_out,
  output logic             irq,
  output logic             watchdog_function_en,
  output logic             wd_reset,
  output logic             wd_cause
);
  typedef struct packed {
    logic [3:0]  div12;
    logic [1:0]  div4;
    logic        eci_s1;
    logic        eci_s2;
    logic        eci_s3;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    logic [2:0]  osc_div;
    logic [15:0] cnt;
    logic        ovf;
    logic        wd_en;
    logic        wd_locked;
    logic [15:0] wd_cmp;
    logic        wd_rst;
    logic        wd_cause;
    logic        irq;
  } cacc_top_st_t;

  cacc_top_st_t st_q;
  cacc_top_st_t st_d;
  logic         tick;
  logic         src_pulse;
  logic         osc_rise;
  logic [4:0]   m_flag;
  logic [4:0]   m_out;
  logic [79:0]  m_cap;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d        = st_q;
    // external pins pass two flops before use
    st_d.eci_s1 = ext_count_input; // R06
    st_d.eci_s2 = st_q.eci_s1;
    st_d.eci_s3 = st_q.eci_s2;
    st_d.osc_s1 = ext_osc;
    st_d.osc_s2 = st_q.osc_s1;
    st_d.osc_s3 = st_q.osc_s2;
    osc_rise    = st_q.osc_s2 & ~st_q.osc_s3;
    // prescalers free-run on sysclk
    st_d.div12  = (st_q.div12 == cacc_pkg::DIV12_LAST) ? 4'h0 : st_q.div12 + 4'h1;
    st_d.div4   = st_q.div4 + 2'h1;
    if (osc_rise) begin // R08
      st_d.osc_div = st_q.osc_div + 3'h1;
    end
    case (clk_sel) // R02
      cacc_pkg::SRC_DIV12:    src_pulse = st_q.div12 == cacc_pkg::DIV12_LAST;
      cacc_pkg::SRC_DIV4:     src_pulse = st_q.div4 == cacc_pkg::DIV4_LAST;
      cacc_pkg::SRC_T0_OVF:   src_pulse = t0_ovf;
      cacc_pkg::SRC_EXT_CNT:  src_pulse = st_q.eci_s2 & ~st_q.eci_s3;
      cacc_pkg::SRC_SYSCLK:   src_pulse = 1'b1;
      cacc_pkg::SRC_OSC_DIV8: src_pulse = osc_rise && st_q.osc_div == cacc_pkg::OSC_DIV_LAST;
      default:                src_pulse = 1'b0;
    endcase
    // halt freezes everything that advances with the count
    tick = src_pulse & (cnt_run | st_q.wd_en) & ~dbg_halt; // R07
    if (tick) begin // R01
      st_d.cnt = st_q.cnt + 16'h0001;
    end
    // overflow flag, set wins over clear
    if (tick && st_q.cnt == 16'hffff) begin // R11
      st_d.ovf = 1'b1;
    end else if (ovf_flag_clr) begin
      st_d.ovf = 1'b0;
    end
    // watchdog on module 4
    if (wd_lock) begin // R09
      st_d.wd_locked = 1'b1;
    end
    if (wd_disable && !st_q.wd_locked && !wd_lock) begin // R09
      st_d.wd_en = 1'b0;
    end
    if (wd_kick && st_q.wd_en) begin // R04
      st_d.wd_cmp = st_q.cnt + {wd_offset, 8'h00};
    end
    st_d.wd_rst = st_q.wd_en & tick & (st_q.cnt == st_q.wd_cmp) & ~wd_kick; // R10
    if (st_d.wd_rst) begin // R10
      st_d.wd_cause = 1'b1;
    end else if (wd_cause_clr) begin
      st_d.wd_cause = 1'b0;
    end
    st_d.irq = (st_q.ovf & ovf_irq_en) | (|(m_flag & mod_irq_en)); // R11
  end

  always_ff @(posedge clk) begin
    if (!por_b) begin
      st_q        <= '0;
      st_q.wd_en  <= cacc_pkg::WD_EN_RST;
      st_q.wd_cmp <= cacc_pkg::WD_CMP_RST;
    end else if (!rst_b) begin
      st_q          <= '0;
      st_q.cnt      <= cacc_pkg::CNT_RST;
      st_q.wd_en    <= cacc_pkg::WD_EN_RST; // R05
      st_q.wd_cmp   <= cacc_pkg::WD_CMP_RST;
      st_q.wd_cause <= st_q.wd_cause; // cause survives system reset
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // capture/compare modules
  for (genvar i = 0; i < cacc_pkg::NMOD; i++) begin : g_mod
    cacc_pkg::cacc_mode_t m_mode;
    // module 4 is held off while it serves as watchdog
    assign m_mode = (i == cacc_pkg::WD_MOD && st_q.wd_en) ? cacc_pkg::CACC_OFF :
                    cacc_pkg::cacc_mode_t'(mode_sel[i*3 +: 3]); // R04
    cacc_module u_mod (
      .clk         (clk),
      .rst_b       (rst_b),
      .count       (st_q.cnt),
      .tick        (tick),
      .mode        (m_mode),
      .cap_rise_en (cap_rise_en[i]),
      .cap_fall_en (cap_fall_en[i]),
      .cmp_val     (cmp_val[i*16 +: 16]),
      .cmp_wr      (cmp_wr[i]),
      .pin_in      (mod_pin_in[i]),
      .flag_clr    (mod_flag_clr[i]),
      .cap_val     (m_cap[i*16 +: 16]),
      .flag        (m_flag[i]),
      .pin_out     (m_out[i])
    );
  end

  assign count                = st_q.cnt;
  assign cap_val              = m_cap;
  assign ovf_flag             = st_q.ovf;
  assign mod_flag             = m_flag;
  assign mod_pin_out          = m_out;
  assign irq                  = st_q.irq;
  assign watchdog_function_en = st_q.wd_en;
  assign wd_reset             = st_q.wd_rst;
  assign wd_cause             = st_q.wd_cause;
endmodule : cacc_top
`default_nettype wire

// *** test/cacc_top_properties.sv ***
`default_nettype none
module cacc_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        por_b,
  input wire logic        dbg_halt,
  input wire logic        ovf_flag_clr,
  input wire logic        ovf_irq_en,
  input wire logic [4:0]  mod_irq_en,
  input wire logic        wd_lock,
  input wire logic        wd_cause_clr,
  input wire logic [15:0] count,
  input wire logic        ovf_flag,
  input wire logic [4:0]  mod_flag,
  input wire logic        irq,
  input wire logic        watchdog_function_en,
  input wire logic        wd_reset,
  input wire logic        wd_cause
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b || !por_b);
  ////////////////////////////////////////////////////////////////
  sequence s_wrap;
    count == 16'hffff ##1 count == 16'h0000;
  endsequence
  sequence s_halted;
    dbg_halt [*2];
  endsequence
  ////////////////////////////////////////////////////////////////
  a_ovf_wrap: assert property (s_wrap |-> ovf_flag) else $error("no flag on wrap");
  a_ovf_sticky: assert property (ovf_flag && !ovf_flag_clr |=> ovf_flag) else $error("flag lost");
  a_halt_freeze: assert property (s_halted |=> $stable(count)) else $error("count moved");
  a_irq_follow: assert property (ovf_flag && ovf_irq_en |=> irq) else $error("irq missing");
  a_irq_quiet: assert property (!(ovf_flag && ovf_irq_en) && (mod_flag & mod_irq_en) == 5'h00
    |=> !irq) else $error("stray irq");
  a_wd_pulse: assert property (wd_reset |=> !wd_reset) else $error("long reset pulse");
  a_wd_cause: assert property (wd_reset && !wd_cause_clr |=> wd_cause) else $error("no cause");
  a_wd_locked: assert property (wd_lock && watchdog_function_en
    |=> watchdog_function_en [*8]) else $error("lock lost");
endmodule : cacc_chk
bind cacc_top cacc_chk u_chk (.clk, .rst_b, .por_b, .dbg_halt, .ovf_flag_clr, .ovf_irq_en,
  .mod_irq_en, .wd_lock, .wd_cause_clr, .count, .ovf_flag, .mod_flag, .irq,
  .watchdog_function_en, .wd_reset, .wd_cause);
`default_nettype wire

// *** test/cacc_pins.sv ***
`default_nettype none
module cacc_pins (
  input  wire logic       cnt_go,
  input  wire logic       osc_go,
  input  wire logic [4:0] pin_lvl,
  output logic            ext_count_input,
  output logic            ext_osc,
  output logic [4:0]      mod_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ext_count_input = 1'b0;
  initial ext_osc = 1'b0;
  always #350 ext_count_input = cnt_go ? ~ext_count_input : 1'b0;
  always #170 ext_osc = osc_go ? ~ext_osc : 1'b0;
  assign mod_pin_in = pin_lvl;
endmodule : cacc_pins
`default_nettype wire

// *** test/tb_cacc_top.sv ***
`default_nettype none
module tb_cacc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, por_b, cnt_run, dbg_halt, t0_ovf, ext_count_input, ext_osc, irq;
  logic        ovf_flag_clr, ovf_irq_en, wd_disable, wd_lock, wd_kick, wd_cause_clr, ovf_flag;
  logic        watchdog_function_en, wd_reset, wd_cause, cnt_go, osc_go;
  logic [2:0]  clk_sel;
  logic [7:0]  wd_offset;
  logic [14:0] mode_sel;
  logic [15:0] count, a;
  logic [79:0] cmp_val, cap_val;
  logic [4:0]  cap_rise_en, cap_fall_en, cmp_wr, mod_pin_in, mod_flag_clr, mod_irq_en, mod_flag;
  logic [4:0]  mod_pin_out, pin_lvl;
  int          n_fail, compares, seed, n_ext, n_osc, n_t0;
  cacc_top uut (.clk, .rst_b, .por_b, .clk_sel, .cnt_run, .dbg_halt, .t0_ovf, .ext_count_input,
    .ext_osc, .mode_sel, .cap_rise_en, .cap_fall_en, .cmp_val, .cmp_wr, .mod_pin_in, .mod_flag_clr,
    .mod_irq_en, .ovf_flag_clr, .ovf_irq_en, .wd_disable, .wd_lock, .wd_kick, .wd_offset,
    .wd_cause_clr, .count, .cap_val, .ovf_flag, .mod_flag, .mod_pin_out, .irq,
    .watchdog_function_en, .wd_reset, .wd_cause);
  cacc_pins pins (.cnt_go, .osc_go, .pin_lvl, .ext_count_input, .ext_osc, .mod_pin_in);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge ext_count_input) n_ext++;
  always @(posedge ext_osc) n_osc++;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse
  task automatic wait_for(ref logic s, input int lim);
    for (int k = 0; k < lim && s !== 1'b1; k++) cyc(1);
    if (s !== 1'b1) begin
      chk("wait", 16'(s), 16'h1);
      close_out;
    end
  endtask : wait_for
  task automatic close_out;
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  function automatic logic [15:0] exp_ticks(input int s, input int n, input int k);
    return 16'(s == 0 ? n / 12 : s == 1 ? n / 4 : s == 4 ? n : k);
  endfunction : exp_ticks
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h6316;
    {rst_b, por_b, cnt_run, dbg_halt, t0_ovf, ovf_flag_clr, ovf_irq_en, wd_disable} = '0;
    {wd_lock, wd_kick, wd_cause_clr, cnt_go, osc_go, clk_sel, wd_offset, mode_sel} = '0;
    {cmp_val, cap_rise_en, cap_fall_en, cmp_wr, mod_flag_clr, mod_irq_en, pin_lvl} = '0;
    cyc(20);
    {rst_b, por_b} = 2'h3;
    cyc(1);
    chk("wd_en", watchdog_function_en, 16'h1);
    chk("cause", wd_cause, 16'h0);
    clk_sel = cacc_pkg::SRC_OSC_DIV8;
    cyc(3);
    a = count;
    osc_go = 1'b1;
    cyc(100);
    osc_go = 1'b0;
    cyc(10);
    chk("osc", count - a, 16'(n_osc / 8));
    pulse(wd_disable);
    chk("wd_off", watchdog_function_en, 16'h0);
    cnt_run = 1'b1;
    for (int s = 0; s < 5; s++) begin
      clk_sel = 3'(s);
      cyc(3);
      {a, n_ext, n_t0, cnt_go} = {count, 64'h0, s == 3};
      for (int i = 0; i < 120; i++) begin
        t0_ovf = (s == 2) && !t0_ovf && ($random(seed) % 3 == 0);
        n_t0 += t0_ovf;
        cyc(1);
      end
      {t0_ovf, cnt_go} = 2'h0;
      if (s == 2 || s == 3) cyc(8);
      chk("ticks", count - a, exp_ticks(s, 120, s == 2 ? n_t0 : n_ext));
    end
    dbg_halt = 1'b1;
    cyc(2);
    a = count;
    cyc(10);
    chk("halt", count, a);
    dbg_halt = 1'b0;
    for (int i = 0; i < 5; i++) begin
      mode_sel[3*i+:3] = cacc_pkg::CACC_CAPTURE;
      a = count;
      {cap_rise_en[i], mod_irq_en[i], pin_lvl[i]} = 3'h7;
      cyc(6);
      chk("cap_val", cap_val[16*i+:16], a + 16'h2);
      chk("cap_flag", mod_flag[i], 16'h1);
      chk("cap_irq", irq, 16'h1);
      {mod_flag_clr[i], mod_irq_en[i]} = 2'h2;
      cyc(1);
      mod_flag_clr[i] = 1'b0;
      cyc(1);
      chk("cap_clr", mod_flag[i], 16'h0);
    end
    // high speed output toggles once at the compare match
    mode_sel[2:0] = cacc_pkg::CACC_HS_OUT;
    cmp_val[15:0] = count + 16'h20;
    cmp_wr[0] = 1'b1;
    cyc(1);
    cmp_wr[0] = 1'b0;
    cyc(40);
    chk("hs_flag", mod_flag[0], 16'h1);
    chk("hs_out", mod_pin_out[0], 16'h1);
    // 16-bit pwm is high while the count is at or above the compare value
    mode_sel[2:0] = cacc_pkg::CACC_PWM16;
    cmp_val[15:0] = 16'h8000;
    cmp_wr[0] = 1'b1;
    cyc(1);
    cmp_wr[0] = 1'b0;
    cyc(2);
    chk("pwm16", mod_pin_out[0], 16'(count - 16'h1 >= 16'h8000));
    ovf_irq_en = 1'b1;
    wait_for(ovf_flag, 70000);
    cyc(2);
    chk("ovf_irq", irq, 16'h1);
    pulse(ovf_flag_clr);
    chk("ovf_clr", ovf_flag, 16'h0);
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    cyc(1);
    chk("wd_rst", watchdog_function_en, 16'h1);
    wd_offset = 8'h01;
    repeat (4) begin
      pulse(wd_kick);
      cyc(200);
    end
    chk("kicked", wd_cause, 16'h0);
    pulse(wd_lock);
    pulse(wd_disable);
    chk("locked", watchdog_function_en, 16'h1);
    wait_for(wd_reset, 300);
    cyc(1);
    chk("wd_cause", wd_cause, 16'h1);
    pulse(wd_cause_clr);
    chk("cause_clr", wd_cause, 16'h0);
    close_out;
  end
endmodule : tb_cacc_top
`default_nettype wire
